/* File: lsa_pkg.sv */
// Package for the load/store/arithmetic/shift execution unit
package lsa_pkg;

	localparam int unsigned DATA_W     = 32;
	localparam int unsigned GROUP_MAX  = 4;
	localparam int unsigned SHAMT_W    = 5;
	localparam int unsigned DIV_STEPS  = 64;
	localparam int unsigned CC_CARRY   = 1;
	localparam int unsigned CC_OVFL    = 0;
	localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
	localparam logic [31:0] WORD_ONE   = 32'h0000_0001;
	localparam logic [2:0]  CC_RESET   = 3'h0;
	localparam logic [6:0]  CNT_ZERO   = 7'h00;
	localparam logic [1:0]  GRP_ONE    = 2'h0;

	// Operation codes issued to the unit
	typedef enum logic [5:0] {
		LSA_OP_MEM_READ_WORD    = 6'h00,
		LSA_OP_MEM_READ_ZBYTE   = 6'h01,
		LSA_OP_MEM_READ_ZHALF   = 6'h02,
		LSA_OP_MEM_READ_SBYTE   = 6'h03,
		LSA_OP_MEM_READ_SHALF   = 6'h04,
		LSA_OP_MEM_WRITE_WORD   = 6'h05,
		LSA_OP_MEM_WRITE_ZBYTE  = 6'h06,
		LSA_OP_MEM_WRITE_ZHALF  = 6'h07,
		LSA_OP_MEM_WRITE_SBYTE  = 6'h08,
		LSA_OP_MEM_WRITE_SHALF  = 6'h09,
		LSA_OP_REG_COPY         = 6'h0a,
		LSA_OP_EFFECTIVE_ADDR   = 6'h0b,
		LSA_OP_ADD_ORD          = 6'h0c,
		LSA_OP_ADD_INT          = 6'h0d,
		LSA_OP_SUB_ORD          = 6'h0e,
		LSA_OP_SUB_INT          = 6'h0f,
		LSA_OP_MUL_ORD          = 6'h10,
		LSA_OP_MUL_INT          = 6'h11,
		LSA_OP_DIV_ORD          = 6'h12,
		LSA_OP_DIV_INT          = 6'h13,
		LSA_OP_ADD_CARRY        = 6'h14,
		LSA_OP_SUB_CARRY        = 6'h15,
		LSA_OP_MUL_WIDE         = 6'h16,
		LSA_OP_DIV_WIDE         = 6'h17,
		LSA_OP_REM_ORD          = 6'h18,
		LSA_OP_REM_INT          = 6'h19,
		LSA_OP_MOD_INT          = 6'h1a,
		LSA_OP_SHL_ORD          = 6'h1b,
		LSA_OP_SHR_ORD          = 6'h1c,
		LSA_OP_SHL_INT          = 6'h1d,
		LSA_OP_SHR_INT          = 6'h1e,
		LSA_OP_SHR_DIV_INT      = 6'h1f,
		LSA_OP_ROTATE           = 6'h20,
		LSA_OP_SHR_PAIR         = 6'h21
	} lsa_op_e;

	// Issue request: operands and group size (count minus one)
	typedef struct packed {
		lsa_op_e     op;
		logic [1:0]  grp;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
		logic [31:0] d;
	} lsa_req_s;

	// Result: up to four register words plus faults
	typedef struct packed {
		logic [3:0][31:0] word;
		logic [1:0]       grp;
		logic             ovfl_fault;
		logic             zdiv_fault;
	} lsa_res_s;

endpackage

/* File: lsa_divider.sv */
// Restoring serial divider, 64-bit dividend by 32-bit divisor
`timescale 1ns/10ps
module lsa_divider #(
	parameter int unsigned STEPS = lsa_pkg::DIV_STEPS
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Request
	input  wire logic        start,
	input  wire logic [63:0] dividend,
	input  wire logic [31:0] divisor,
	// Result
	output logic             done,
	output logic [63:0]      quotient,
	output logic [31:0]      remainder
);

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [6:0]  cnt;
		logic [63:0] quo;
		logic [32:0] rem;
		logic [31:0] dvs;
	} lsa_div_s;

	lsa_div_s st;
	lsa_div_s next_st;
	logic [32:0] trial;

	// One quotient bit per clock; trades latency for a small datapath
	always_comb
	begin
		next_st      = st;
		next_st.done = 1'b0;
		trial        = {st.rem[31:0], st.quo[63]} - {1'b0, st.dvs};
		if (start)
		begin
			next_st.busy = 1'b1;
			next_st.cnt  = 7'(STEPS);
			next_st.quo  = dividend;
			next_st.rem  = 33'h0_0000_0000;
			next_st.dvs  = divisor;
		end
		else if (st.busy)
		begin
			if (!trial[32] || st.rem[31])
				next_st.rem = {1'b0, trial[31:0]};
			else
				next_st.rem = {st.rem[31:0], st.quo[63]};
			next_st.quo = {st.quo[62:0], (!trial[32] || st.rem[31])};
			next_st.cnt = st.cnt - 7'h01;
			if (st.cnt == 7'h01)
			begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st;
	end

	assign done      = st.done;
	assign quotient  = st.quo;
	assign remainder = st.rem[31:0];

endmodule

/* File: lsa_shifter.sv */
// Combinational shift and rotate family
`timescale 1ns/10ps
module lsa_shifter (
	// Operation
	input  wire lsa_pkg::lsa_op_e op,
	input  wire logic [31:0]      src,
	input  wire logic [31:0]      src_hi,
	input  wire logic [31:0]      amount,
	// Result
	output logic [31:0]           result,
	output logic                  ovfl
);

	logic [63:0] pair;
	logic [31:0] asr;
	logic [31:0] lost_mask;
	logic [31:0] sat_shl;
	logic [5:0]  safe;
	logic        big;

	// Counts of 32 or more clear ordinal and dividing shifts; the plain integer right shift fills sign
	always_comb
	begin
		big       = (amount > 32'd31);
		pair      = {src_hi, src} >> (big ? 6'd32 : {1'b0, amount[4:0]});
		asr       = $signed(src) >>> (big ? 6'd31 : {1'b0, amount[4:0]});
		lost_mask = big ? 32'hFFFF_FFFF : ~(32'hFFFF_FFFF << amount[4:0]);
		// Largest left shift that keeps the sign: count redundant sign bits
		safe      = 6'd0;
		for (int i = 30; i >= 0; i--)
			if (src[i] == src[31] && safe == 6'(30 - i))
				safe = 6'(31 - i);
		if (src == lsa_pkg::WORD_ZERO)
			safe = 6'd32;
		ovfl      = 1'b0;
		sat_shl   = src;
		result    = lsa_pkg::WORD_ZERO;
		unique case (op)
			lsa_pkg::LSA_OP_SHL_ORD:
				result = big ? lsa_pkg::WORD_ZERO : src << amount[4:0];
			lsa_pkg::LSA_OP_SHR_ORD:
				result = big ? lsa_pkg::WORD_ZERO : src >> amount[4:0];
			lsa_pkg::LSA_OP_SHL_INT:
			begin
				ovfl = (amount > {26'h0, safe});
				sat_shl = ovfl ? (src << safe[4:0]) : (src << amount[4:0]);
				result = (src == lsa_pkg::WORD_ZERO) ? src : sat_shl;
			end
			lsa_pkg::LSA_OP_SHR_INT:
				result = asr;
			lsa_pkg::LSA_OP_SHR_DIV_INT:
				result = asr + ((src[31] && |(src & lost_mask)) ?
					lsa_pkg::WORD_ONE : lsa_pkg::WORD_ZERO);
			lsa_pkg::LSA_OP_ROTATE:
				result = (src << amount[4:0]) | (src >> (6'd32 - {1'b0, amount[4:0]}));
			lsa_pkg::LSA_OP_SHR_PAIR:
				result = pair[31:0];
			default:
				result = lsa_pkg::WORD_ZERO;
		endcase
	end

endmodule

/* File: lsa_unit.sv */
// Load/store, move, address, arithmetic and shift execution unit
// How it works
// - Word to quad loads fill consecutive registers
// - Word to quad stores drain consecutive registers
// - Byte/half loads zero- or sign-extend
// - Signed narrow stores flag out-of-range values
// - Unsigned narrow stores truncate, never fault
// - Address op returns the address itself
// - Signed arithmetic overflow raises fault
// - Divide by zero raises zero-divide fault
// - Carry ops use and update carry bit
// - Carry ops set signed-overflow bit
// - Wide multiply gives 64-bit unsigned product
// - Wide divide gives quotient and remainder
// - Remainder follows dividend, modulo follows divisor
// - Ordinal shifts drop bits, fill zeros
// - Integer left shift stops at the largest sign-keeping count and flags
// - Integer right shift is arithmetic
// - Dividing shift rounds negatives toward zero
// - Rotate wraps bit 31 into bit 0
// - Pair shift returns low word
`timescale 1ns/10ps
module lsa_unit (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// Issue
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire lsa_pkg::lsa_req_s req,
	// Arithmetic control word bits
	input  wire logic              ovfl_mask,
	input  wire logic              cc_clear,
	output logic [2:0]             cond_code,
	output logic                   ovfl_flag,
	// Result
	output logic                   res_valid,
	output lsa_pkg::lsa_res_s      res
);

	typedef enum logic [2:0] {
		LSA_IDLE = 3'b001,
		LSA_DIV  = 3'b010,
		LSA_DONE = 3'b100
	} lsa_state_e;

	typedef struct packed {
		lsa_state_e        state;
		lsa_pkg::lsa_op_e  op;
		logic [31:0]       a;
		logic [31:0]       b;
		logic [2:0]        cc;
		logic              ovfl_flag;
		logic              res_valid;
		lsa_pkg::lsa_res_s res;
	} lsa_unit_s;

	lsa_unit_s st;
	lsa_unit_s next_st;

	logic        div_start;
	logic [63:0] div_dividend;
	logic [31:0] div_divisor;
	logic        div_done;
	logic [63:0] div_quo;
	logic [31:0] div_rem;
	logic [31:0] shf_result;
	logic        shf_ovfl;

	// Magnitude of a signed word for the signed divide paths
	function automatic logic [31:0] abs_word(input logic [31:0] v);
		abs_word = v[31] ? (~v + lsa_pkg::WORD_ONE) : v;
	endfunction

	// Negate when the flag is set
	function automatic logic [31:0] neg_if(input logic [31:0] v, input logic n);
		neg_if = n ? (~v + lsa_pkg::WORD_ONE) : v;
	endfunction

	// Only the divide family occupies the serial divider
	function automatic logic is_div(input lsa_pkg::lsa_op_e o);
		is_div = (o == lsa_pkg::LSA_OP_DIV_ORD) || (o == lsa_pkg::LSA_OP_DIV_INT) ||
			(o == lsa_pkg::LSA_OP_DIV_WIDE) || (o == lsa_pkg::LSA_OP_REM_ORD) ||
			(o == lsa_pkg::LSA_OP_REM_INT) || (o == lsa_pkg::LSA_OP_MOD_INT);
	endfunction

	lsa_shifter u_shifter (
		.op     (req.op),
		.src    (req.a),
		.src_hi (req.b),
		.amount (req.c),
		.result (shf_result),
		.ovfl   (shf_ovfl)
	);

	lsa_divider #(
		.STEPS (lsa_pkg::DIV_STEPS)
	) u_divider (
		.clk       (clk),
		.reset     (reset),
		.start     (div_start),
		.dividend  (div_dividend),
		.divisor   (div_divisor),
		.done      (div_done),
		.quotient  (div_quo),
		.remainder (div_rem)
	);

	// Divider operands: signed ops divide magnitudes and fix signs afterwards
	always_comb
	begin
		div_start    = 1'b0;
		div_divisor  = req.b;
		div_dividend = {lsa_pkg::WORD_ZERO, req.a};
		if (req.op == lsa_pkg::LSA_OP_DIV_WIDE)
			div_dividend = {req.d, req.a};
		else if (req.op == lsa_pkg::LSA_OP_DIV_INT || req.op == lsa_pkg::LSA_OP_REM_INT ||
			req.op == lsa_pkg::LSA_OP_MOD_INT)
		begin
			div_dividend = {lsa_pkg::WORD_ZERO, abs_word(req.a)};
			div_divisor  = abs_word(req.b);
		end
		if (st.state == LSA_IDLE && req_valid && is_div(req.op) &&
			req.b != lsa_pkg::WORD_ZERO)
			div_start = 1'b1;
	end

	// Main datapath and sequencing
	always_comb
	begin
		logic [32:0] sum;
		logic [63:0] prod;
		logic [63:0] sprod;
		logic        ovf;
		logic        cin;
		logic [31:0] r;
		logic [31:0] q;
		logic        zero;
		sum   = 33'h0_0000_0000;
		prod  = 64'h0000_0000_0000_0000;
		sprod = 64'h0000_0000_0000_0000;
		ovf   = 1'b0;
		cin   = st.cc[lsa_pkg::CC_CARRY];
		r     = lsa_pkg::WORD_ZERO;
		q     = lsa_pkg::WORD_ZERO;
		zero  = 1'b0;
		next_st           = st;
		next_st.res_valid = 1'b0;
		if (cc_clear)
		begin
			next_st.cc        = lsa_pkg::CC_RESET;
			next_st.ovfl_flag = 1'b0;
		end
		unique case (st.state)
			LSA_IDLE:
			begin
				if (req_valid)
				begin
					next_st.op             = req.op;
					next_st.a              = req.a;
					next_st.b              = req.b;
					next_st.res            = '0;
					next_st.res.grp        = grp_sel(req.op, req.grp);
					next_st.res.word       = {req.d, req.c, req.b, req.a};
					next_st.res_valid      = 1'b1;
					unique case (req.op)
						lsa_pkg::LSA_OP_MEM_READ_ZBYTE:
							next_st.res.word[0] = {24'h00_0000, req.a[7:0]};
						lsa_pkg::LSA_OP_MEM_READ_ZHALF:
							next_st.res.word[0] = {16'h0000, req.a[15:0]};
						lsa_pkg::LSA_OP_MEM_READ_SBYTE:
							next_st.res.word[0] = {{24{req.a[7]}}, req.a[7:0]};
						lsa_pkg::LSA_OP_MEM_READ_SHALF:
							next_st.res.word[0] = {{16{req.a[15]}}, req.a[15:0]};
						lsa_pkg::LSA_OP_MEM_WRITE_ZBYTE:
							next_st.res.word[0] = {24'h00_0000, req.a[7:0]};
						lsa_pkg::LSA_OP_MEM_WRITE_ZHALF:
							next_st.res.word[0] = {16'h0000, req.a[15:0]};
						lsa_pkg::LSA_OP_MEM_WRITE_SBYTE:
						begin
							next_st.res.word[0] = {24'h00_0000, req.a[7:0]};
							ovf = (req.a[31:7] != {25{req.a[7]}});
						end
						lsa_pkg::LSA_OP_MEM_WRITE_SHALF:
						begin
							next_st.res.word[0] = {16'h0000, req.a[15:0]};
							ovf = (req.a[31:15] != {17{req.a[15]}});
						end
						lsa_pkg::LSA_OP_EFFECTIVE_ADDR:
							next_st.res.word[0] = req.a + req.b;
						lsa_pkg::LSA_OP_ADD_ORD:
							next_st.res.word[0] = req.a + req.b;
						lsa_pkg::LSA_OP_SUB_ORD:
							next_st.res.word[0] = req.a - req.b;
						lsa_pkg::LSA_OP_ADD_INT:
						begin
							r   = req.a + req.b;
							ovf = (req.a[31] == req.b[31]) && (r[31] != req.a[31]);
							next_st.res.word[0] = r;
						end
						lsa_pkg::LSA_OP_SUB_INT:
						begin
							r   = req.a - req.b;
							ovf = (req.a[31] != req.b[31]) && (r[31] != req.a[31]);
							next_st.res.word[0] = r;
						end
						lsa_pkg::LSA_OP_MUL_ORD:
							next_st.res.word[0] = 32'(req.a * req.b);
						lsa_pkg::LSA_OP_MUL_INT:
						begin
							sprod = 64'($signed(req.a) * $signed(req.b));
							ovf   = (sprod[63:31] != {33{sprod[31]}});
							next_st.res.word[0] = sprod[31:0];
						end
						lsa_pkg::LSA_OP_MUL_WIDE:
						begin
							prod = {32'h0000_0000, req.a} * {32'h0000_0000, req.b};
							next_st.res.word[0] = prod[31:0];
							next_st.res.word[1] = prod[63:32];
						end
						lsa_pkg::LSA_OP_ADD_CARRY:
						begin
							sum = {1'b0, req.a} + {1'b0, req.b} + {32'h0, cin};
							next_st.res.word[0] = sum[31:0];
							next_st.cc[lsa_pkg::CC_CARRY] = sum[32];
							next_st.cc[lsa_pkg::CC_OVFL] = (req.a[31] == req.b[31]) &&
								(sum[31] != req.a[31]);
						end
						lsa_pkg::LSA_OP_SUB_CARRY:
						begin
							sum = {1'b0, req.a} + {1'b0, ~req.b} + {32'h0, cin};
							next_st.res.word[0] = sum[31:0];
							next_st.cc[lsa_pkg::CC_CARRY] = sum[32];
							next_st.cc[lsa_pkg::CC_OVFL] = (req.a[31] != req.b[31]) &&
								(sum[31] != req.a[31]);
						end
						lsa_pkg::LSA_OP_SHL_ORD, lsa_pkg::LSA_OP_SHR_ORD,
						lsa_pkg::LSA_OP_SHR_INT, lsa_pkg::LSA_OP_SHR_DIV_INT,
						lsa_pkg::LSA_OP_ROTATE, lsa_pkg::LSA_OP_SHR_PAIR:
							next_st.res.word[0] = shf_result;
						lsa_pkg::LSA_OP_SHL_INT:
						begin
							next_st.res.word[0] = shf_result;
							ovf = shf_ovfl;
						end
						default:
						begin
							if (is_div(req.op))
							begin
								zero = (req.b == lsa_pkg::WORD_ZERO);
								next_st.res.zdiv_fault = zero;
								next_st.res_valid      = zero;
								next_st.state          = zero ? LSA_IDLE : LSA_DIV;
							end
						end
					endcase
					// Masked overflow sets the sticky flag, else a fault
					if (ovf && ovfl_mask)
						next_st.ovfl_flag = 1'b1;
					next_st.res.ovfl_fault = ovf && !ovfl_mask;
				end
			end
			LSA_DIV:
			begin
				if (div_done)
				begin
					q = div_quo[31:0];
					r = div_rem;
					next_st.res_valid = 1'b1;
					next_st.state     = LSA_IDLE;
					unique case (st.op)
						lsa_pkg::LSA_OP_DIV_WIDE:
						begin
							next_st.res.word[0] = r;
							next_st.res.word[1] = q;
						end
						lsa_pkg::LSA_OP_DIV_INT:
						begin
							q   = neg_if(q, st.a[31] ^ st.b[31]);
							ovf = (q[31] != (st.a[31] ^ st.b[31])) && (q != lsa_pkg::WORD_ZERO);
							next_st.res.word[0] = q;
						end
						lsa_pkg::LSA_OP_REM_INT:
							next_st.res.word[0] = neg_if(r, st.a[31]);
						lsa_pkg::LSA_OP_MOD_INT:
						begin
							r = neg_if(r, st.a[31]);
							if (r != lsa_pkg::WORD_ZERO && (r[31] != st.b[31]))
								r = r + st.b;
							next_st.res.word[0] = r;
						end
						lsa_pkg::LSA_OP_REM_ORD:
							next_st.res.word[0] = r;
						default:
							next_st.res.word[0] = q;
					endcase
					if (ovf && ovfl_mask)
						next_st.ovfl_flag = 1'b1;
					next_st.res.ovfl_fault = ovf && !ovfl_mask;
				end
			end
			default:
				next_st.state = LSA_IDLE;
		endcase
	end

	// Group size: word loads, stores and copies take the requested size; wide multiply and divide use two words
	function automatic logic [1:0] grp_sel(input lsa_pkg::lsa_op_e o, input logic [1:0] g);
		grp_sel = (o == lsa_pkg::LSA_OP_MEM_READ_WORD || o == lsa_pkg::LSA_OP_MEM_WRITE_WORD ||
			o == lsa_pkg::LSA_OP_REG_COPY) ? g :
			((o == lsa_pkg::LSA_OP_MUL_WIDE || o == lsa_pkg::LSA_OP_DIV_WIDE) ? 2'h1 :
			lsa_pkg::GRP_ONE);
	endfunction

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st       <= '0;
			st.state <= LSA_IDLE;
		end
		else
			st <= next_st;
	end

	// Outputs: ready is combinational, data from flip-flops
	assign req_ready = (st.state == LSA_IDLE);
	assign cond_code = st.cc;
	assign ovfl_flag = st.ovfl_flag;
	assign res_valid = st.res_valid;
	assign res       = st.res;

endmodule

/* File: lsa_unit_chk.sv */
// Port-level assertion checker for the execution unit
`timescale 1ns/10ps
module lsa_unit_chk (
	// Clock and reset
	input wire logic              clk,
	input wire logic              reset,
	// Issue
	input wire logic              req_valid,
	input wire logic              req_ready,
	input wire lsa_pkg::lsa_req_s req,
	// Control word bits
	input wire logic              ovfl_mask,
	input wire logic              cc_clear,
	input wire logic [2:0]        cond_code,
	input wire logic              ovfl_flag,
	// Result
	input wire logic              res_valid,
	input wire lsa_pkg::lsa_res_s res
);
	logic              tk;
	logic              mk;
	lsa_pkg::lsa_req_s q;
	logic [32:0]       sum;
	logic [31:0]       add;
	logic [63:0]       rot;
	logic              aov;
	// Taken request kept one cycle so each result can be tied to its cause
	always_ff @(posedge clk)
	begin
		tk  <= !reset && req_valid && req_ready;
		mk  <= ovfl_mask;
		q   <= req;
		sum <= {1'b0, req.a} + {1'b0, req.b} + {32'h0000_0000, cond_code[1]};
	end
	// Plain sum and rotate image of the held request
	assign add = q.a + q.b;
	assign aov = (q.a[31] == q.b[31]) && (add[31] != q.a[31]);
	assign rot = {q.a, q.a} << q.c[4:0];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_load_word: assert property (tk && q.op == lsa_pkg::LSA_OP_MEM_READ_WORD
		|-> res_valid && res.word[0] == q.a) else $error("word load data wrong");
	a_store_quad: assert property (tk && q.op == lsa_pkg::LSA_OP_MEM_WRITE_WORD
		&& q.grp == 2'h3 |-> res.word[3] == q.d && res.word[2] == q.c)
		else $error("quad store words wrong");
	a_sign_extend: assert property (tk && q.op == lsa_pkg::LSA_OP_MEM_READ_SBYTE
		|-> res.word[0] == {{24{q.a[7]}}, q.a[7:0]}) else $error("byte sign fill wrong");
	a_trunc_nofault: assert property (tk && (q.op == lsa_pkg::LSA_OP_MEM_WRITE_ZBYTE
		|| q.op == lsa_pkg::LSA_OP_MEM_WRITE_ZHALF) |-> !res.ovfl_fault)
		else $error("unsigned narrow store faulted");
	a_addr_calc: assert property (tk && q.op == lsa_pkg::LSA_OP_EFFECTIVE_ADDR
		|-> res_valid && res.word[0] == add) else $error("address result wrong");
	a_add_fault: assert property (tk && q.op == lsa_pkg::LSA_OP_ADD_INT
		|-> res.ovfl_fault == (aov && !mk)) else $error("add fault wrong");
	a_mask_flag: assert property (tk && q.op == lsa_pkg::LSA_OP_ADD_INT && aov && mk
		|-> ovfl_flag) else $error("masked overflow left flag clear");
	a_zero_div: assert property (tk && q.op == lsa_pkg::LSA_OP_DIV_ORD && q.b == 0
		|-> res_valid && res.zdiv_fault) else $error("zero divisor not faulted");
	a_carry_chain: assert property (tk && q.op == lsa_pkg::LSA_OP_ADD_CARRY
		|-> cond_code[1] == sum[32] && res.word[0] == sum[31:0]) else $error("carry add wrong");
	a_wide_mult: assert property (tk && q.op == lsa_pkg::LSA_OP_MUL_WIDE
		|-> {res.word[1], res.word[0]} == {32'h0000_0000, q.a} * {32'h0000_0000, q.b})
		else $error("wide product wrong");
	a_shr_fill: assert property (tk && q.op == lsa_pkg::LSA_OP_SHR_ORD && q.c < 32
		|-> res.word[0] == q.a >> q.c) else $error("right shift fill wrong");
	a_rotate_wrap: assert property (tk && q.op == lsa_pkg::LSA_OP_ROTATE
		|-> res.word[0] == rot[63:32]) else $error("rotate result wrong");
endmodule
bind lsa_unit lsa_unit_chk u_chk (.clk(clk), .reset(reset), .req_valid(req_valid),
	.req_ready(req_ready), .req(req), .ovfl_mask(ovfl_mask), .cc_clear(cc_clear),
	.cond_code(cond_code), .ovfl_flag(ovfl_flag), .res_valid(res_valid), .res(res));

/* File: lsa_mem_model.sv */
// Memory-side model: words that a grouped load fetches
`timescale 1ns/10ps
module lsa_mem_model (
	// Fetch
	input  wire logic [3:0]  base,
	input  wire logic [1:0]  grp,
	// Data
	output logic [3:0][31:0] word
);
	logic [3:0] al;
	// Groups start aligned; words past the group are scrambled, not left stale
	always_comb
	begin
		al = (grp == 2'h0) ? base : (grp == 2'h1) ? {base[3:1], 1'b0} : {base[3:2], 2'h0};
		for (int i = 0; i < 4; i++)
			word[i] = (32'(al) + 32'(i)) * 32'h9e37_79b9 ^ ((i > grp) ? 32'hffff_ffff : 32'h0000_0000);
	end
endmodule

/* File: load_store_arith_shift_unit_tb.sv */
// Self-checking testbench for the execution unit
`timescale 1ns/10ps
module load_store_arith_shift_unit_tb;
	logic                    clk;
	logic                    reset;
	logic                    req_valid;
	logic                    req_ready;
	lsa_pkg::lsa_req_s       req;
	logic                    ovfl_mask;
	logic                    cc_clear;
	logic [2:0]              cond_code;
	logic                    ovfl_flag;
	logic                    res_valid;
	lsa_pkg::lsa_res_s       res;
	logic [3:0]              mem_base;
	logic [1:0]              mem_grp;
	logic [3:0][31:0]        mem_word;
	logic [1:0]              cc;
	logic                    flg;
	int                      n_errors;
	int                      n_checks;

	lsa_unit dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .ovfl_mask(ovfl_mask), .cc_clear(cc_clear), .cond_code(cond_code),
		.ovfl_flag(ovfl_flag), .res_valid(res_valid), .res(res));
	lsa_mem_model mem (.base(mem_base), .grp(mem_grp), .word(mem_word));

	// Free-running 8 ns clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic complete_run();
		if (n_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Expected result; n counts result words defined for the op
	function automatic lsa_pkg::lsa_res_s model(lsa_pkg::lsa_req_s r, logic ci,
		output logic [1:0] ncc, output int n);
		lsa_pkg::lsa_res_s  e;
		logic signed [31:0] sa, sb, m, t;
		logic signed [63:0] ps;
		logic [63:0]        p, w;
		logic [32:0]        s, sc;
		logic [31:0]        ad, su;
		int                 k;
		e = '0;
		e.word = {r.d, r.c, r.b, r.a};
		sa = r.a;
		sb = r.b;
		k = (r.c > 31) ? 31 : int'(r.c);
		p = {32'h0000_0000, r.a} * {32'h0000_0000, r.b};
		ps = 64'(sa) * 64'(sb);
		w = {r.d, r.a};
		ad = r.a + r.b;
		su = r.a - r.b;
		m = (r.b == 0) ? 0 : sa % sb;
		t = sa >>> k;
		s = {1'b0, r.a} + {1'b0, r.b} + {32'h0000_0000, ci};
		sc = {1'b0, r.a} + {1'b0, ~r.b} + {32'h0000_0000, ci};
		ncc = (r.op == lsa_pkg::LSA_OP_SUB_CARRY) ? {sc[32], r.a[31] != r.b[31] && sc[31] != r.a[31]}
			: {s[32], r.a[31] == r.b[31] && s[31] != r.a[31]};
		n = (r.op inside {lsa_pkg::LSA_OP_MUL_WIDE, lsa_pkg::LSA_OP_DIV_WIDE}) ? 2 : 1;
		case (r.op)
			lsa_pkg::LSA_OP_MEM_READ_WORD, lsa_pkg::LSA_OP_MEM_WRITE_WORD,
			lsa_pkg::LSA_OP_REG_COPY: n = int'(r.grp) + 1;
			lsa_pkg::LSA_OP_MEM_READ_ZBYTE, lsa_pkg::LSA_OP_MEM_WRITE_ZBYTE,
			lsa_pkg::LSA_OP_MEM_WRITE_SBYTE: e.word[0] = {24'h00_0000, r.a[7:0]};
			lsa_pkg::LSA_OP_MEM_READ_ZHALF, lsa_pkg::LSA_OP_MEM_WRITE_ZHALF,
			lsa_pkg::LSA_OP_MEM_WRITE_SHALF: e.word[0] = {16'h0000, r.a[15:0]};
			lsa_pkg::LSA_OP_MEM_READ_SBYTE: e.word[0] = {{24{r.a[7]}}, r.a[7:0]};
			lsa_pkg::LSA_OP_MEM_READ_SHALF: e.word[0] = {{16{r.a[15]}}, r.a[15:0]};
			lsa_pkg::LSA_OP_EFFECTIVE_ADDR, lsa_pkg::LSA_OP_ADD_ORD,
			lsa_pkg::LSA_OP_ADD_INT: e.word[0] = ad;
			lsa_pkg::LSA_OP_SUB_ORD, lsa_pkg::LSA_OP_SUB_INT: e.word[0] = su;
			lsa_pkg::LSA_OP_MUL_ORD, lsa_pkg::LSA_OP_MUL_INT: e.word[0] = p[31:0];
			lsa_pkg::LSA_OP_DIV_ORD: e.word[0] = r.a / r.b;
			lsa_pkg::LSA_OP_DIV_INT: e.word[0] = sa / sb;
			lsa_pkg::LSA_OP_ADD_CARRY: e.word[0] = s[31:0];
			lsa_pkg::LSA_OP_SUB_CARRY: e.word[0] = sc[31:0];
			lsa_pkg::LSA_OP_MUL_WIDE: e.word[1:0] = p;
			lsa_pkg::LSA_OP_DIV_WIDE: e.word[1:0] = {32'(w / r.b), 32'(w % r.b)};
			lsa_pkg::LSA_OP_REM_ORD: e.word[0] = r.a % r.b;
			lsa_pkg::LSA_OP_REM_INT: e.word[0] = m;
			lsa_pkg::LSA_OP_MOD_INT: e.word[0] = (m != 0 && m[31] != sb[31]) ? m + sb : m;
			lsa_pkg::LSA_OP_SHL_INT,
			lsa_pkg::LSA_OP_SHL_ORD: e.word[0] = (r.c > 31) ? 32'h0000_0000 : r.a << r.c;
			lsa_pkg::LSA_OP_SHR_ORD: e.word[0] = (r.c > 31) ? 32'h0000_0000 : r.a >> r.c;
			lsa_pkg::LSA_OP_SHR_INT: e.word[0] = t;
			lsa_pkg::LSA_OP_SHR_DIV_INT: e.word[0] = (sa < 0 && (r.a << (32 - k)) != 0) ? t + 1 : t;
			lsa_pkg::LSA_OP_ROTATE: e.word[0] = 32'(({r.a, r.a} << r.c[4:0]) >> 32);
			lsa_pkg::LSA_OP_SHR_PAIR: e.word[0] = 32'({r.b, r.a} >> r.c);
			default: n = 0;
		endcase
		// Raw overflow; the mask decides later between fault and flag
		case (r.op)
			lsa_pkg::LSA_OP_MEM_WRITE_SBYTE: e.ovfl_fault = sa > 127 || sa < -128;
			lsa_pkg::LSA_OP_MEM_WRITE_SHALF: e.ovfl_fault = sa > 32767 || sa < -32768;
			lsa_pkg::LSA_OP_ADD_INT: e.ovfl_fault = r.a[31] == r.b[31] && ad[31] != r.a[31];
			lsa_pkg::LSA_OP_SUB_INT: e.ovfl_fault = r.a[31] != r.b[31] && su[31] != r.a[31];
			lsa_pkg::LSA_OP_MUL_INT: e.ovfl_fault = ps[63:31] != {33{ps[31]}};
			lsa_pkg::LSA_OP_DIV_INT: e.ovfl_fault = r.a == 32'h8000_0000 && r.b == 32'hffff_ffff;
			lsa_pkg::LSA_OP_SHL_INT: e.ovfl_fault = ((sa <<< k) >>> k) != sa;
			default: e.ovfl_fault = 1'b0;
		endcase
		e.zdiv_fault = r.b == 0 && r.op inside {lsa_pkg::LSA_OP_DIV_ORD, lsa_pkg::LSA_OP_DIV_INT,
			lsa_pkg::LSA_OP_REM_ORD, lsa_pkg::LSA_OP_REM_INT, lsa_pkg::LSA_OP_MOD_INT,
			lsa_pkg::LSA_OP_DIV_WIDE};
		if (e.zdiv_fault || e.ovfl_fault && r.op inside {lsa_pkg::LSA_OP_SHL_INT,
			lsa_pkg::LSA_OP_DIV_INT})
			n = 0;
		return e;
	endfunction

	// One request: hold for one cycle, scramble after, wait bounded for the result
	task automatic run(lsa_pkg::lsa_req_s r, logic mk);
		lsa_pkg::lsa_res_s e;
		logic [1:0]        ncc;
		int                n;
		int                w;
		e = model(r, cc[1], ncc, n);
		@(posedge clk);
		req_valid <= 1'b1;
		req       <= r;
		ovfl_mask <= mk;
		@(posedge clk);
		req_valid <= 1'b0;
		req       <= ~r;
		@(negedge clk);
		for (w = 0; w < 90 && res_valid !== 1'b1; w++)
			@(negedge clk);
		check("res_valid", 32'(res_valid), 32'h0000_0001);
		if (n > 0)
			check("word0", res.word[0], e.word[0]);
		for (int i = 1; i < n; i++)
			check("word", res.word[i], e.word[i]);
		check("ovfl_fault", 32'(res.ovfl_fault), 32'(e.ovfl_fault & !mk));
		check("zdiv_fault", 32'(res.zdiv_fault), 32'(e.zdiv_fault));
		flg = flg | (e.ovfl_fault & mk);
		check("ovfl_flag", 32'(ovfl_flag), 32'(flg));
		if (r.op inside {lsa_pkg::LSA_OP_ADD_CARRY, lsa_pkg::LSA_OP_SUB_CARRY})
		begin
			cc = ncc;
			check("cond_code", 32'(cond_code[1:0]), 32'(cc));
		end
	endtask

	function automatic lsa_pkg::lsa_req_s mk(lsa_pkg::lsa_op_e op, logic [31:0] a, b, c);
		return '{op, 2'h3, a, b, c, '0};
	endfunction

	// Hang guard, above 412 requests of at most 70 cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	// Reset, corner cases, random traffic, then a flag clear
	initial
	begin
		lsa_pkg::lsa_req_s r;
		{reset, req_valid, ovfl_mask, cc_clear, req} = {4'h8, 136'h0};
		{mem_base, mem_grp, cc, flg, n_errors, n_checks} = '0;
		void'($urandom(71));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check("reset", 32'({req_ready, res_valid, cond_code, ovfl_flag}), 32'h0000_0020);
		run(mk(lsa_pkg::LSA_OP_ADD_INT, 32'h7fff_ffff, 32'h0000_0001, 0), 1'b0);
		run(mk(lsa_pkg::LSA_OP_ADD_INT, 32'h7fff_ffff, 32'h0000_0001, 0), 1'b1);
		run(mk(lsa_pkg::LSA_OP_MEM_WRITE_SBYTE, 32'h0000_0080, 0, 0), 1'b0);
		run(mk(lsa_pkg::LSA_OP_MEM_WRITE_ZBYTE, 32'hffff_ff80, 0, 0), 1'b0);
		run(mk(lsa_pkg::LSA_OP_DIV_ORD, 32'h0000_0007, 0, 0), 1'b0);
		run(mk(lsa_pkg::LSA_OP_DIV_WIDE, 32'h0000_0007, 0, 0), 1'b0);
		run(mk(lsa_pkg::LSA_OP_SHL_INT, 32'h4000_0000, 0, 32'h0000_0001), 1'b0);
		run(mk(lsa_pkg::LSA_OP_SHR_DIV_INT, 32'hffff_fffb, 0, 32'h0000_0001), 1'b0);
		run(mk(lsa_pkg::LSA_OP_MOD_INT, 32'hffff_fff9, 32'h0000_0003, 0), 1'b0);
		run(mk(lsa_pkg::LSA_OP_ADD_CARRY, 32'hffff_ffff, 32'h0000_0001, 0), 1'b0);
		run(mk(lsa_pkg::LSA_OP_ADD_CARRY, 32'h7fff_ffff, 0, 0), 1'b0);
		run(mk(lsa_pkg::LSA_OP_SHR_PAIR, 32'h0000_0001, 32'h8765_4321, 32'h0000_0020), 1'b0);
		for (int i = 0; i < 400; i++)
		begin
			r.op = lsa_pkg::lsa_op_e'(6'($urandom % 34));
			{r.grp, r.a, r.b, r.d} = {2'($urandom), $urandom, $urandom, $urandom};
			r.c = $urandom % ((r.op == lsa_pkg::LSA_OP_SHR_PAIR) ? 33 : 32);
			if ($urandom % 4 == 0)
				r.b = $urandom % 8;
			if (r.op == lsa_pkg::LSA_OP_DIV_WIDE && r.b != 0)
				r.d = r.d % r.b;
			if (r.op <= lsa_pkg::LSA_OP_MEM_READ_SHALF)
			begin
				{mem_base, mem_grp} = {4'($urandom), r.grp};
				#1 {r.d, r.c, r.b, r.a} = mem_word;
			end
			run(r, 1'($urandom));
		end
		@(posedge clk);
		cc_clear <= 1'b1;
		@(posedge clk);
		cc_clear <= 1'b0;
		@(negedge clk);
		check("cleared", 32'({cond_code, ovfl_flag}), 32'h0000_0000);
		complete_run();
	end
endmodule
